// ==== verilog/ser_pkg.sv ====
// Package of constants and carrier types for the serial channel event block.
// Assumes a single 40 MHz module clock and synchronous active-high reset.
package ser_pkg;

  // ------------------------------------------------------------------
  // Control register layout
  // ------------------------------------------------------------------
  localparam int MODE_LSB      = 0;
  localparam int MODE_MSB      = 2;
  localparam int PARITY_ERR_BIT = 8;
  localparam int FRAME_ERR_BIT = 9;
  localparam int OVRUN_ERR_BIT = 10;
  localparam int PARITY_SEL_BIT = 12;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ------------------------------------------------------------------
  // Frame mode encodings
  // ------------------------------------------------------------------
  localparam logic [2:0] MODE_SYNC8     = 3'h0;
  localparam logic [2:0] MODE_ASYNC8    = 3'h1;
  localparam logic [2:0] MODE_ASYNC7P   = 3'h3;
  localparam logic [2:0] MODE_ASYNC8P   = 3'h7;

  // ------------------------------------------------------------------
  // Baud reload values and pulse timing
  // ------------------------------------------------------------------
  localparam int RELOAD_W = 13;
  localparam logic [12:0] RELOAD_RESET = 13'h0000;
  localparam logic [12:0] RELOAD_TABLE [0:8] = '{
    13'h0002, 13'h0005, 13'h000B, 13'h0011, 13'h0023,
    13'h0047, 13'h008F, 13'h011F, 13'h023F};
  localparam int PULSE_CYCLES = 2;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SER_FMT_7P  = 2'b00,
    SER_FMT_8P  = 2'b01,
    SER_FMT_8N  = 2'b10
  } ser_format_type;

  typedef struct packed {
    logic           valid;      // One-cycle detection strobe; success only with rate_index 8 or less.
    ser_format_type format;
    logic           odd;
    logic [3:0]     rate_index;
  } ser_detect_type;

  typedef struct packed {
    logic valid;       // Frame completed and moved to receive buffer.
    logic stop_low;    // Any expected stop bit sampled low.
    logic parity_bad;  // Received parity mismatches selected parity.
  } ser_rx_done_type;

  typedef struct packed {
    logic tx_buffer;
    logic transmit;
    logic receive;
    logic error;
    logic ab_start;
    logic ab_detected;
  } ser_irq_type;

endpackage

// ==== verilog/ser_event_ctrl.sv ====
// Event, error flag and autobaud write-back logic of the async serial channel.
// Assumes the shift datapath and detector drive one-cycle strobes on clk.
`timescale 1ns/10ps

// What this block does
// - On detection success, overwrite only mode field and parity-select bit.
// - Mode 011 for 7-bit parity, 111 for 8-bit parity, 001 without.
// - Load 13-bit baud reload from nine-entry table by detected rate index.
// - Error interrupt pulses in same cycle as receive interrupt.
// - Async only: enabled framing check sets framing flag on low stop bit.
// - Async parity modes: enabled parity check flags mismatch.
// - Enabled overrun check flags frame completing before buffer was read.
// - Four main interrupt outputs pulse exactly two clock periods.
// - Error flags stay set until software clears them.
// - Transmit-buffer interrupt pulses on buffer-to-shifter move.
// - Transmit interrupt: async before last bit, sync after last bit.
// - Receive interrupt pulses when frame enters receive buffer.
// - Buffer may be rewritten while shifter still sends previous word.
// - Autobaud start interrupt per start bit when all three enables set.
// - Autobaud detected interrupt after second character on success.
// - First-character enable adds detected interrupt after first char.
// - Error flags at bits 8, 9, 10; set only while check enabled.
// - Mode at bits 2..0, parity select at 12; software and hardware write.
module ser_event_ctrl (
  input  wire logic                  clk,               // Module clock, 40 MHz.
  input  wire logic                  sys_rst,           // Synchronous reset, high.
  input  wire logic                  ctrl_wr,           // Software write strobe.
  input  wire logic [15:0]           ctrl_wdata,        // Software write data.
  input  wire logic                  reload_wr,         // Software reload write strobe.
  input  wire logic [12:0]           reload_wdata,      // Software reload data.
  input  wire logic                  framing_check_enable, // Framing check on.
  input  wire logic                  parity_check_enable,  // Parity check on.
  input  wire logic                  overrun_check_enable, // Overrun check on.
  input  wire logic                  rbuf_read,         // Receive buffer read strobe.
  input  wire ser_pkg::ser_rx_done_type rx_done,        // Frame-complete strobe.
  input  wire logic                  tbuf_to_shift,     // Buffer moved to shifter.
  input  wire logic                  tx_before_last,    // Async: last bit about to go.
  input  wire logic                  tx_after_last,     // Sync: last bit sent.
  input  wire logic                  autobaud_unit_enable,       // Autobaud unit on.
  input  wire logic                  autobaud_detect_enable,     // Detection on.
  input  wire logic                  autobaud_start_irq_enable,  // Start irq on.
  input  wire logic                  first_char_detect_enable,   // First-char irq on.
  input  wire logic                  start_bit_seen,    // Start bit during detection.
  input  wire logic                  first_char_seen,   // First character recognised.
  input  wire ser_pkg::ser_detect_type detect,          // Detection result strobe.
  output logic [15:0]                channel_control_reg,    // Control and flags.
  output logic [12:0]                baud_timer_reload_reg,  // Baud reload value.
  output ser_pkg::ser_irq_type       irq                     // Interrupt lines.
);

  // ------------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------------
  function automatic logic [2:0] fmt_to_mode(input ser_pkg::ser_format_type f);
    unique case (f)
      ser_pkg::SER_FMT_7P: fmt_to_mode = ser_pkg::MODE_ASYNC7P;
      ser_pkg::SER_FMT_8P: fmt_to_mode = ser_pkg::MODE_ASYNC8P;
      default:             fmt_to_mode = ser_pkg::MODE_ASYNC8;
    endcase
  endfunction

  wire logic [2:0] cur_mode   = channel_control_reg[ser_pkg::MODE_MSB:ser_pkg::MODE_LSB];
  wire logic       is_async   = (cur_mode != ser_pkg::MODE_SYNC8);
  wire logic       has_parity = (cur_mode == ser_pkg::MODE_ASYNC7P) ||
                                (cur_mode == ser_pkg::MODE_ASYNC8P);
  wire logic       rate_ok    = detect.rate_index <= 4'h8;
  wire logic       det_ok     = detect.valid && rate_ok;

  // Set by a completed frame, cleared by a read of the receive buffer.
  logic        unread;

  // Error causes for the frame completing in this cycle.
  wire logic set_fe = rx_done.valid && framing_check_enable && is_async &&
                      rx_done.stop_low;
  wire logic set_pe = rx_done.valid && parity_check_enable && is_async &&
                      has_parity && rx_done.parity_bad;
  wire logic set_oe = rx_done.valid && overrun_check_enable && unread;
  wire logic any_err = set_fe || set_pe || set_oe;

  // ------------------------------------------------------------------
  // Control register next value
  // ------------------------------------------------------------------
  logic [15:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrl_wr ? ctrl_wdata : channel_control_reg;
    if (det_ok) begin
      next_ctrl[ser_pkg::MODE_MSB:ser_pkg::MODE_LSB] = fmt_to_mode(detect.format);
      next_ctrl[ser_pkg::PARITY_SEL_BIT] =
        (detect.format == ser_pkg::SER_FMT_8N) ? 1'b0 : detect.odd;
    end
    // Hardware set wins over a software clear in the same cycle.
    if (set_pe) next_ctrl[ser_pkg::PARITY_ERR_BIT] = 1'b1;
    if (set_fe) next_ctrl[ser_pkg::FRAME_ERR_BIT]  = 1'b1;
    if (set_oe) next_ctrl[ser_pkg::OVRUN_ERR_BIT]  = 1'b1;
  end

  wire logic [12:0] next_reload =
    det_ok    ? ser_pkg::RELOAD_TABLE[detect.rate_index] :
    reload_wr ? reload_wdata : baud_timer_reload_reg;

  // ------------------------------------------------------------------
  // Interrupt requests
  // ------------------------------------------------------------------
  wire logic req_tb  = tbuf_to_shift;
  wire logic req_tx  = is_async ? tx_before_last : tx_after_last;
  wire logic req_rx  = rx_done.valid;
  wire logic req_er  = rx_done.valid && any_err;
  wire logic ab_run  = autobaud_unit_enable && autobaud_detect_enable;
  wire logic req_abs = ab_run && autobaud_start_irq_enable && start_bit_seen;
  wire logic req_abd = (ab_run && first_char_detect_enable && first_char_seen) ||
                       det_ok;

  // Each stretch register holds the request from the previous cycle so the
  // output stays high for two clocks per request.
  logic [3:0] held;
  wire  logic [3:0] req4 = {req_tb, req_tx, req_rx, req_er};
  wire  logic [3:0] next_irq4 = req4 | held;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel_control_reg   <= ser_pkg::CTRL_RESET;
      baud_timer_reload_reg <= ser_pkg::RELOAD_RESET;
      unread                <= 1'b0;
      held                  <= 4'h0;
      irq                   <= '0;
    end else begin
      channel_control_reg   <= next_ctrl;
      baud_timer_reload_reg <= next_reload;
      unread                <= rx_done.valid ? 1'b1 : (rbuf_read ? 1'b0 : unread);
      held                  <= req4;
      irq.tx_buffer         <= next_irq4[3];
      irq.transmit          <= next_irq4[2];
      irq.receive           <= next_irq4[1];
      irq.error             <= next_irq4[0];
      irq.ab_start          <= req_abs;
      irq.ab_detected       <= req_abd;
    end
  end

endmodule // ser_event_ctrl

// ==== bench/ser_far_model.sv ====
// Far-side model: autobaud detector strobes only; the bench drives the receive strobes.
// Assumes the bench pulses go for one cycle per two-character detection.
`timescale 1ns/10ps
module ser_far_model (
  input  wire logic                    clk,             // Module clock.
  input  wire logic                    sys_rst,         // Synchronous reset, high.
  input  wire logic                    go,              // Start a detection sequence.
  input  wire logic [1:0]              fmt,             // Detected format.
  input  wire logic                    odd,             // Detected odd parity.
  input  wire logic [3:0]              idx,             // Detected rate index.
  output logic                         start_bit_seen,  // Start bit of a character.
  output logic                         first_char_seen, // First character recognised.
  output ser_pkg::ser_detect_type      detect           // Detection strobe and result.
);
  logic [3:0] s;
  logic [6:0] res;
  always_ff @(posedge clk) begin
    s <= sys_rst ? 4'h0 : {s[2:0], go};
    if (go) res <= {fmt, odd, idx};
  end
  assign start_bit_seen  = s[0] | s[2];
  assign first_char_seen = s[1];
  // Result fields are scrambled outside the strobe so stale values cannot pass.
  assign detect = {s[3], s[3] ? res : ~res};
endmodule // ser_far_model

// ==== bench/ser_event_properties.sv ====
// Checker of irq timing, error flags and autobaud write-back.
// Bound to the event block; sees only its ports.
`timescale 1ns/10ps
module ser_event_properties (
  input wire logic clk, sys_rst, ctrl_wr, reload_wr, framing_check_enable, tbuf_to_shift,
  input wire logic tx_before_last, tx_after_last, start_bit_seen, autobaud_unit_enable,
  input wire logic autobaud_detect_enable, autobaud_start_irq_enable,
  input wire ser_pkg::ser_rx_done_type rx_done,        // Frame strobe.
  input wire ser_pkg::ser_detect_type  detect,         // Detection strobe.
  input wire logic [15:0]              channel_control_reg,   // Control and flags.
  input wire logic [12:0]              baud_timer_reload_reg, // Reload value.
  input wire ser_pkg::ser_irq_type     irq             // Interrupt lines.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_bad_stop;
    rx_done.valid && rx_done.stop_low && framing_check_enable && channel_control_reg[2:0] != 3'h0;
  endsequence
  sequence s_good_det;
    detect.valid && detect.rate_index <= 4'h8;
  endsequence
  property p_err_rcv; s_bad_stop |=> irq.receive && irq.error; endproperty
  a_err_rcv: assert property (p_err_rcv) else $error("error irq not with receive irq");
  property p_fe_set; s_bad_stop |=> channel_control_reg[9]; endproperty
  a_fe_set: assert property (p_fe_set) else $error("framing flag not set");
  property p_fe_hold; channel_control_reg[9] && !ctrl_wr |=> channel_control_reg[9]; endproperty
  a_fe_hold: assert property (p_fe_hold) else $error("framing flag dropped");
  property p_tb_high; tbuf_to_shift |=> irq.tx_buffer [*2]; endproperty
  a_tb_high: assert property (p_tb_high) else $error("tx buffer irq short");
  property p_tb_end; tbuf_to_shift ##1 !tbuf_to_shift [*2] |=> !irq.tx_buffer; endproperty
  a_tb_end: assert property (p_tb_end) else $error("tx buffer irq long");
  property p_reload; s_good_det |=>
    baud_timer_reload_reg == ser_pkg::RELOAD_TABLE[$past(detect.rate_index)]; endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong");
  property p_det_irq; s_good_det |=> irq.ab_detected; endproperty
  a_det_irq: assert property (p_det_irq) else $error("detected irq missing");
  property p_keep; s_good_det ##0 !ctrl_wr && !rx_done.valid |=>
    $stable(channel_control_reg[11:3]) && $stable(channel_control_reg[15:13]); endproperty
  a_keep: assert property (p_keep) else $error("other control bits changed");
  property p_fail; detect.valid && detect.rate_index > 4'h8 && !ctrl_wr && !reload_wr |=>
    $stable(baud_timer_reload_reg) && $stable(channel_control_reg[2:0]); endproperty
  a_fail: assert property (p_fail) else $error("failed detection changed state");
  property p_tx_irq; (channel_control_reg[2:0] != 3'h0 ? tx_before_last : tx_after_last)
    |=> irq.transmit; endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("transmit irq missing");
  property p_abs_irq; autobaud_unit_enable && autobaud_detect_enable &&
    autobaud_start_irq_enable && start_bit_seen |=> irq.ab_start; endproperty
  a_abs_irq: assert property (p_abs_irq) else $error("autobaud start irq missing");
endmodule // ser_event_properties

// ==== bench/test_serial_error_irq_autobaud_update.sv ====
// Bench: random frames and detections; notes expected flags, regs and error irq.
// Assumes the far-side model and the checker compile before it.
`timescale 1ns/10ps
module test_serial_error_irq_autobaud_update;
  logic clk = 0, sys_rst = 1, ctrl_wr = 0, reload_wr = 0, rbuf_read = 0, go = 0, odd = 0;
  logic fen = 0, pen = 0, oen = 0, tbs = 0, tbl = 0, tal = 0, fce = 0, sbs, fcs, unread = 0;
  logic fe, pe, oe;
  logic [15:0] cw = 0, ctrl, ec = 0;
  logic [12:0] rw = 0, rel, er = 0;
  logic [1:0] fmt = 0;
  logic [3:0] idx = 0;
  logic [2:0] mt [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [31:0] n;
  logic [29:0] q[$], got, exp_v;
  ser_pkg::ser_rx_done_type rxd = '0;
  ser_pkg::ser_detect_type det;
  ser_pkg::ser_irq_type irq, pirq = '0;
  int fail_count = 0, cmp_count = 0;
  ser_event_ctrl i_ser_event_ctrl (.clk(clk), .sys_rst(sys_rst), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(cw), .reload_wr(reload_wr), .reload_wdata(rw), .framing_check_enable(fen),
    .parity_check_enable(pen), .overrun_check_enable(oen), .rbuf_read(rbuf_read),
    .rx_done(rxd), .tbuf_to_shift(tbs), .tx_before_last(tbl), .tx_after_last(tal),
    .autobaud_unit_enable(1'b1), .autobaud_detect_enable(1'b1),
    .autobaud_start_irq_enable(1'b1), .first_char_detect_enable(fce), .start_bit_seen(sbs),
    .first_char_seen(fcs), .detect(det), .channel_control_reg(ctrl),
    .baud_timer_reload_reg(rel), .irq(irq));
  ser_far_model i_ser_far_model (.clk(clk), .sys_rst(sys_rst), .go(go), .fmt(fmt), .odd(odd),
    .idx(idx), .start_bit_seen(sbs), .first_char_seen(fcs), .detect(det));
  initial forever #12.5 clk = ~clk;
  task automatic end_of_test;
    if (q.size() != 0) fail_count++;
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #75000;
    fail_count++;
    end_of_test;
  end
  always @(posedge clk) begin
    pirq <= irq;
    if ((irq.receive && !pirq.receive) || (irq.ab_detected && !pirq.ab_detected)) begin
      got = {irq.error, ctrl, rel};
      exp_v = q.size() ? q.pop_front() : 'x;
      cmp_count++;
      if (got !== exp_v) begin
        fail_count++;
        $display("MISMATCH err_ctrl_reload exp %h got %h", exp_v, got);
      end
    end
  end
  initial begin
    n = $urandom(32'h70CDBD0F);
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    for (int t = 0; t < 60; t++) begin
      n = $urandom;
      if (t % 3 == 0) begin
        ec = {n[15:11], 3'h0, n[7:3], mt[(t / 3) % 4]};
        er = n[28:16];
        {cw, rw, ctrl_wr, reload_wr} <= {ec, er, 2'h3};
        @(posedge clk);
        {ctrl_wr, reload_wr} <= 2'h0;
      end
      {rbuf_read, fen, pen, oen, tbs, tbl, tal} <= n[6:0];
      @(posedge clk);
      {rbuf_read, tbs, tbl, tal} <= 4'h0;
      rxd <= {1'b1, n[8:7]};
      fe = n[5] & n[8] & (ec[2:0] != 3'h0);
      pe = n[4] & n[7] & (ec[1:0] == 2'h3);
      oe = n[3] & unread & !n[6];
      unread = 1;
      ec[10:8] = ec[10:8] | {oe, fe, pe};
      q.push_back({fe | pe | oe, ec, er});
      repeat (4) @(posedge clk) rxd <= '0;
      n[11] = n[11] & !n[12];
      {fce, go, fmt, odd, idx} <= {n[9], 1'b1, n[12:10], n[16:13]};
      if (n[9]) q.push_back({1'b0, ec, er});
      if (n[16:13] <= 4'h8) begin
        ec[2:0] = n[12] ? 3'h1 : (n[11] ? 3'h7 : 3'h3);
        ec[12] = n[10] & !n[12];
        er = ser_pkg::RELOAD_TABLE[n[16:13]];
        q.push_back({1'b0, ec, er});
      end
      repeat (10) @(posedge clk) go <= 0;
    end
    end_of_test;
  end
endmodule // test_serial_error_irq_autobaud_update
bind ser_event_ctrl ser_event_properties i_ser_event_properties (.clk(clk), .sys_rst(sys_rst),
  .ctrl_wr(ctrl_wr), .reload_wr(reload_wr), .framing_check_enable(framing_check_enable),
  .tbuf_to_shift(tbuf_to_shift), .rx_done(rx_done), .detect(detect), .irq(irq),
  .tx_before_last(tx_before_last), .tx_after_last(tx_after_last),
  .start_bit_seen(start_bit_seen), .autobaud_unit_enable(autobaud_unit_enable),
  .autobaud_detect_enable(autobaud_detect_enable),
  .autobaud_start_irq_enable(autobaud_start_irq_enable),
  .channel_control_reg(channel_control_reg), .baud_timer_reload_reg(baud_timer_reload_reg));
